// ### hw/clock_control.sv
// Overview of operation
// - disable write of one stops peripheral clock
// - state bits read one when clock runs
// - enable bit starts oscillator, bypass kept clear
// - stable flag rises after programmed start-up
// - bypass uses external input, stable immediately
// - clearing enable and bypass clears stable
// - start-up equals count times 8 slow
// - count main cycles over 16 slow periods
// - valid bit low until measurement available
// - input divider zero stops, one bypasses
// - lock waits lock count slow cycles after write
// - ratio zero stops PLL, else ratio plus one
// - usb clock divides PLL by 1,2,4
// - source select slow, main, PLL clock
// - prescale codes divide by 1 to 64
// - programmable outputs each have own select and prescale
// - prescaled switch adds 64 new-source cycles
// - status stable flag shows oscillator stable
// - status lock flag shows PLL locked
`timescale 1ns/1ns
`default_nettype none

module clock_control
	import clock_control_pkg::*;
#(
	parameter int NPCK = 3
) (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire logic slow_clk_pin, // slow clock
	input wire logic osc_clk_pin, // crystal cell output
	input wire logic osc_input_pin, // external clock on bypass
	input wire logic pll_clk_pin, // PLL macro output
	output logic crystal_osc_on, // crystal cell enable
	output logic external_clock_passthrough, // crystal cell bypass
	output logic [7:0] pll_div_value, // PLL input divider
	output logic [10:0] pll_ratio_factor, // PLL multiplier
	output logic [1:0] pll_range, // PLL frequency range
	output logic pll_run, // PLL active
	output logic usb_clk, // divided PLL clock
	output logic master_clk, // master clock
	output logic [NPCK-1:0] prog_clk, // programmable outputs
	output logic master_ready, // master clock settled
	output logic [31:0] periph_clk_en // peripheral clock gates
);

	localparam int NGEN = NPCK + 1;

	// =========================================================
	// helpers
	function automatic logic pick_src(input logic [1:0] sel, input logic [2:0] v);
		logic r;
		r = 1'b0;
		if (sel == SRC_SLOW) begin
			r = v[0];
		end else if (sel == SRC_MAIN) begin
			r = v[1];
		end else if (sel == SRC_PLL) begin
			r = v[2];
		end
		return r;
	endfunction

	function automatic logic [5:0] half_period(input logic [2:0] scale);
		logic [6:0] full;
		full = 7'h01 << scale;
		return full[6:1];
	endfunction

	// =========================================================
	// pin synchronisers; stage one feeds stage two only
	logic [3:0] sync1_reg, sync2_reg, sync3_reg;
	logic slow_rise, main_rise, pll_rise, main_lvl;
	logic [2:0] rise_vec, lvl_vec;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
		end else begin
			sync1_reg <= {pll_clk_pin, osc_input_pin, osc_clk_pin, slow_clk_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	logic on_reg, bypass_reg;
	logic [3:0] rise4;
	assign rise4 = sync2_reg & ~sync3_reg;
	assign slow_rise = rise4[0];
	// main clock is the crystal, or the external input when bypassed
	assign main_rise = bypass_reg ? rise4[2] : (on_reg & rise4[1]);
	assign main_lvl = bypass_reg ? sync2_reg[2] : (on_reg & sync2_reg[1]);
	assign pll_rise = pll_run & rise4[3];
	assign rise_vec = {pll_rise, main_rise, slow_rise};
	assign lvl_vec = {pll_run & sync2_reg[3], main_lvl, sync2_reg[0]};

	// =========================================================
	// AHB-Lite slave: zero wait states
	logic wr_en_reg;
	logic [7:0] wr_addr_reg;
	logic addr_ok;
	logic [31:0] rd_value;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel & htrans[1] & hready & (haddr[31:8] == 24'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
			hrdata <= 32'h0;
		end else begin
			wr_en_reg <= addr_ok & hwrite;
			wr_addr_reg <= {haddr[7:2], 2'b00};
			if (addr_ok && !hwrite) begin
				hrdata <= rd_value;
			end
		end
	end

	// =========================================================
	// peripheral clock gating
	logic [31:0] per_en_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_en_reg <= 32'h0;
		end else if (wr_en_reg && wr_addr_reg == OFF_PER_ENABLE) begin
			per_en_reg <= per_en_reg | (hwdata & PER_MASK);
		end else if (wr_en_reg && wr_addr_reg == OFF_PER_DISABLE) begin
			per_en_reg <= per_en_reg & ~(hwdata & PER_MASK);
		end
	end

	assign periph_clk_en = per_en_reg;

	// =========================================================
	// main oscillator and start-up
	logic [7:0] startup_reg;
	logic [10:0] start_cnt_reg;
	logic [10:0] start_target;
	logic stable_reg, osc_off;

	assign start_target = {startup_reg, 3'b000};
	assign osc_off = !on_reg && !bypass_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_reg <= 1'b0;
			bypass_reg <= 1'b0;
			startup_reg <= 8'h0;
		end else if (wr_en_reg && wr_addr_reg == OFF_OSC_CTRL) begin
			on_reg <= hwdata[OSC_ON_BIT];
			bypass_reg <= hwdata[BYPASS_BIT];
			startup_reg <= hwdata[STARTUP_LSB +: 8];
		end
	end

	// both bits set is a software fault; bypass wins so no crystal clock is used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_cnt_reg <= 11'h0;
			stable_reg <= 1'b0;
		end else if (osc_off) begin
			start_cnt_reg <= 11'h0;
			stable_reg <= 1'b0;
		end else if (bypass_reg) begin
			stable_reg <= 1'b1;
		end else if (!stable_reg) begin
			if (start_cnt_reg >= start_target) begin
				stable_reg <= 1'b1;
			end else if (slow_rise) begin
				start_cnt_reg <= start_cnt_reg + 11'h1;
			end
		end
	end

	assign crystal_osc_on = on_reg & ~bypass_reg;
	assign external_clock_passthrough = bypass_reg;

	// =========================================================
	// main clock measurement, one shot after the oscillator settles
	logic meas_busy_reg, meas_valid_reg;
	logic [4:0] win_reg;
	logic [15:0] meas_cnt_reg, meas_result_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_busy_reg <= 1'b0;
			meas_valid_reg <= 1'b0;
			win_reg <= 5'h0;
			meas_cnt_reg <= 16'h0;
			meas_result_reg <= 16'h0;
		end else if (osc_off) begin
			meas_busy_reg <= 1'b0;
			meas_valid_reg <= 1'b0;
			win_reg <= 5'h0;
		end else if (!meas_busy_reg) begin
			if (stable_reg && !meas_valid_reg && slow_rise) begin
				meas_busy_reg <= 1'b1;
				win_reg <= 5'h0;
				meas_cnt_reg <= 16'h0;
			end
		end else begin
			if (main_rise && meas_cnt_reg != 16'hffff) begin
				meas_cnt_reg <= meas_cnt_reg + 16'h1;
			end
			if (slow_rise) begin
				win_reg <= win_reg + 5'h1;
				if (win_reg + 5'h1 == MEAS_WINDOW) begin
					meas_busy_reg <= 1'b0;
					meas_valid_reg <= 1'b1;
					meas_result_reg <= meas_cnt_reg;
				end
			end
		end
	end

	// =========================================================
	// PLL configuration and lock wait
	logic [31:0] pll_reg;
	logic [5:0] lock_cnt_reg;
	logic lock_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_reg <= PLL_RESET;
		end else if (wr_en_reg && wr_addr_reg == OFF_PLL_CFG) begin
			pll_reg <= hwdata & PLL_MASK;
		end
	end

	assign pll_div_value = pll_reg[PLL_DIV_LSB +: 8];
	assign pll_ratio_factor = pll_reg[PLL_MUL_LSB +: 11];
	assign pll_range = pll_reg[PLL_RANGE_LSB +: 2];
	// divider zero gives no input and ratio zero stops the PLL
	assign pll_run = (pll_div_value != 8'h0) && (pll_ratio_factor != 11'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_cnt_reg <= 6'h0;
			lock_reg <= 1'b0;
		end else if ((wr_en_reg && wr_addr_reg == OFF_PLL_CFG) || !pll_run) begin
			lock_cnt_reg <= 6'h0;
			lock_reg <= 1'b0;
		end else if (!lock_reg) begin
			if (lock_cnt_reg >= pll_reg[PLL_CNT_LSB +: 6]) begin
				lock_reg <= 1'b1;
			end else if (slow_rise) begin
				lock_cnt_reg <= lock_cnt_reg + 6'h1;
			end
		end
	end

	// =========================================================
	// usb clock from PLL edges
	logic [1:0] usb_cnt_reg;
	logic usb_reg;
	logic [1:0] usb_sel;
	assign usb_sel = pll_reg[PLL_USB_LSB +: 2];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb_cnt_reg <= 2'h0;
			usb_reg <= 1'b0;
		end else if (usb_sel == USB_DIV1) begin
			usb_reg <= lvl_vec[2];
		end else if (usb_sel == USB_DIV2 || usb_sel == USB_DIV4) begin
			if (pll_rise) begin
				if (usb_sel == USB_DIV2 || usb_cnt_reg[0]) begin
					usb_reg <= ~usb_reg;
					usb_cnt_reg <= 2'h0;
				end else begin
					usb_cnt_reg <= usb_cnt_reg + 2'h1;
				end
			end
		end else begin
			usb_reg <= 1'b0;
		end
	end

	assign usb_clk = usb_reg;

	// =========================================================
	// clock generators: index 0 is the master clock
	logic [4:0] want_reg [NGEN];
	logic [4:0] act_reg [NGEN];
	gen_state_type st_reg [NGEN];
	logic [5:0] div_cnt_reg [NGEN];
	logic [6:0] settle_reg [NGEN];
	logic [NGEN-1:0] gclk_reg, ready_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NGEN; i++) begin
				want_reg[i] <= 5'h0;
			end
		end else if (wr_en_reg) begin
			for (int i = 0; i < NGEN; i++) begin
				if (wr_addr_reg == (i == 0 ? OFF_MCK_SEL : OFF_PCK_BASE + 8'((i - 1) * 4))) begin
					want_reg[i] <= hwdata[4:0];
				end
			end
		end
	end

	// a new setting is taken only while the output is low, so no pulse is cut short
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NGEN; i++) begin
				act_reg[i] <= 5'h0;
				st_reg[i] <= GEN_RUN;
				div_cnt_reg[i] <= 6'h0;
				settle_reg[i] <= 7'h0;
			end
			gclk_reg <= '0;
			ready_reg <= NGEN'(1);
		end else begin
			for (int i = 0; i < NGEN; i++) begin
				if (act_reg[i][4:2] == SCALE_NONE) begin
					gclk_reg[i] <= pick_src(act_reg[i][1:0], lvl_vec);
				end else if (act_reg[i][4:2] == SCALE_RESERVED) begin
					gclk_reg[i] <= 1'b0;
				end else if (pick_src(act_reg[i][1:0], rise_vec)) begin
					if (div_cnt_reg[i] + 6'h1 >= half_period(act_reg[i][4:2])) begin
						gclk_reg[i] <= ~gclk_reg[i];
						div_cnt_reg[i] <= 6'h0;
					end else begin
						div_cnt_reg[i] <= div_cnt_reg[i] + 6'h1;
					end
				end
				unique case (st_reg[i])
					GEN_RUN: begin
						if (want_reg[i] != act_reg[i]) begin
							st_reg[i] <= GEN_WAIT_LOW;
							ready_reg[i] <= 1'b0;
						end
					end
					GEN_WAIT_LOW: begin
						if (!gclk_reg[i]) begin
							act_reg[i] <= want_reg[i];
							div_cnt_reg[i] <= 6'h0;
							settle_reg[i] <= 7'h0;
							if (want_reg[i][4:2] == SCALE_NONE) begin
								st_reg[i] <= GEN_RUN;
								ready_reg[i] <= 1'b1;
							end else begin
								st_reg[i] <= GEN_SETTLE;
							end
						end
					end
					GEN_SETTLE: begin
						if (want_reg[i] != act_reg[i]) begin
							st_reg[i] <= GEN_WAIT_LOW;
						end else if (pick_src(act_reg[i][1:0], rise_vec)) begin
							settle_reg[i] <= settle_reg[i] + 7'h1;
							if (settle_reg[i] + 7'h1 == SWITCH_EXTRA) begin
								st_reg[i] <= GEN_RUN;
								ready_reg[i] <= 1'b1;
							end
						end
					end
					default: begin
						st_reg[i] <= GEN_RUN;
					end
				endcase
			end
		end
	end

	assign master_clk = gclk_reg[0];
	assign prog_clk = gclk_reg[NGEN-1:1];
	assign master_ready = ready_reg[0];

	// =========================================================
	// read mux
	always_comb begin
		rd_value = 32'h0;
		if (haddr[7:0] == OFF_PER_STATE) begin
			rd_value = per_en_reg;
		end else if (haddr[7:0] == OFF_OSC_CTRL) begin
			rd_value = {16'h0, startup_reg, 6'h0, bypass_reg, on_reg};
		end else if (haddr[7:0] == OFF_MEASURE) begin
			rd_value = {15'h0, meas_valid_reg, meas_result_reg};
		end else if (haddr[7:0] == OFF_PLL_CFG) begin
			rd_value = pll_reg;
		end else if (haddr[7:0] == OFF_STATUS) begin
			rd_value[ST_STABLE_BIT] = stable_reg;
			rd_value[ST_LOCK_BIT] = lock_reg;
			rd_value[ST_MCK_READY_BIT] = ready_reg[0];
			rd_value[ST_PCK_READY_LSB +: NPCK] = ready_reg[NGEN-1:1];
		end else begin
			for (int i = 0; i < NGEN; i++) begin
				if (haddr[7:0] == (i == 0 ? OFF_MCK_SEL : OFF_PCK_BASE + 8'((i - 1) * 4))) begin
					rd_value = {27'h0, want_reg[i]};
				end
			end
		end
	end

	// =========================================================
	// checks
	property p_disable_clears;
		@(posedge hclk) disable iff (!hresetn)
		(wr_en_reg && wr_addr_reg == OFF_PER_DISABLE) |=> ((periph_clk_en & $past(hwdata)) == 32'h0);
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("disable write left clock on");

	property p_state_read;
		@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr[7:0] == OFF_PER_STATE) |=> (hrdata == $past(periph_clk_en));
	endproperty
	a_state_read: assert property (p_state_read) else $error("state read differs from gates");

	property p_bypass_stable;
		@(posedge hclk) disable iff (!hresetn)
		bypass_reg |=> stable_reg;
	endproperty
	a_bypass_stable: assert property (p_bypass_stable) else $error("bypass did not set stable");

	property p_off_clears;
		@(posedge hclk) disable iff (!hresetn)
		(!on_reg && !bypass_reg) |=> !stable_reg ##0 !meas_valid_reg;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("flags not cleared when oscillator off");

	property p_startup_time;
		@(posedge hclk) disable iff (!hresetn)
		$rose(stable_reg) |-> ($past(bypass_reg) || $past(start_cnt_reg) >= $past(start_target));
	endproperty
	a_startup_time: assert property (p_startup_time) else $error("stable raised before start-up");

	property p_lock_restart;
		@(posedge hclk) disable iff (!hresetn)
		(wr_en_reg && wr_addr_reg == OFF_PLL_CFG) |=> !lock_reg ##1 (!lock_reg || pll_reg[13:8] == 6'h0);
	endproperty
	a_lock_restart: assert property (p_lock_restart) else $error("lock not restarted by write");

	property p_window_length;
		@(posedge hclk) disable iff (!hresetn)
		$rose(meas_valid_reg) |-> ($past(win_reg) == 5'hf && $past(slow_rise));
	endproperty
	a_window_length: assert property (p_window_length) else $error("window not 16 slow periods");

	property p_switch_extra;
		@(posedge hclk) disable iff (!hresetn)
		($rose(ready_reg[0]) && $past(st_reg[0]) == GEN_SETTLE) |-> ($past(settle_reg[0]) == 7'h3f);
	endproperty
	a_switch_extra: assert property (p_switch_extra) else $error("prescaled switch not 64 cycles");

	property p_lock_needs_pll;
		@(posedge hclk) disable iff (!hresetn)
		lock_reg |-> (pll_ratio_factor != 11'h0 && pll_div_value != 8'h0);
	endproperty
	a_lock_needs_pll: assert property (p_lock_needs_pll) else $error("lock with PLL stopped");

endmodule

`default_nettype wire

// ### hw/clock_control_pkg.sv
package clock_control_pkg;

	// =========================================================
	// bus and timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam logic [7:0] OFF_PER_ENABLE = 8'h10;
	localparam logic [7:0] OFF_PER_DISABLE = 8'h14;
	localparam logic [7:0] OFF_PER_STATE = 8'h18;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
	localparam logic [7:0] OFF_MEASURE = 8'h24;
	localparam logic [7:0] OFF_PLL_CFG = 8'h2c;
	localparam logic [7:0] OFF_MCK_SEL = 8'h30;
	localparam logic [7:0] OFF_PCK_BASE = 8'h40;
	localparam logic [7:0] OFF_STATUS = 8'h68;

	// =========================================================
	// field layout and reset values
	localparam logic [31:0] PER_MASK = 32'hffff_fffc;
	localparam int OSC_ON_BIT = 0;
	localparam int BYPASS_BIT = 1;
	localparam int STARTUP_LSB = 8;
	localparam int STARTUP_SCALE = 3;
	localparam int MEAS_VALID_BIT = 16;
	localparam logic [4:0] MEAS_WINDOW = 5'h10;
	localparam int PLL_DIV_LSB = 0;
	localparam int PLL_CNT_LSB = 8;
	localparam int PLL_RANGE_LSB = 14;
	localparam int PLL_MUL_LSB = 16;
	localparam int PLL_USB_LSB = 28;
	localparam logic [31:0] PLL_MASK = 32'h37ff_ffff;
	localparam logic [31:0] PLL_RESET = 32'h0000_3f00;
	localparam int ST_STABLE_BIT = 0;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_MCK_READY_BIT = 3;
	localparam int ST_PCK_READY_LSB = 8;
	localparam logic [6:0] SWITCH_EXTRA = 7'h40;

	// =========================================================
	// encodings
	localparam logic [1:0] SRC_SLOW = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [2:0] SCALE_NONE = 3'h0;
	localparam logic [2:0] SCALE_RESERVED = 3'h7;
	localparam logic [1:0] USB_DIV1 = 2'h0;
	localparam logic [1:0] USB_DIV2 = 2'h1;
	localparam logic [1:0] USB_DIV4 = 2'h2;

	typedef enum logic [2:0] {
		GEN_RUN = 3'b001,
		GEN_WAIT_LOW = 3'b010,
		GEN_SETTLE = 3'b100
	} gen_state_type;

endpackage

// ### test/clock_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin error_cnt++; $display("ERROR %0t %s", $time, msg); end end

module clock_control_tb
	import clock_control_pkg::*;
;
	// =========================================================
	// signals and design
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans, pll_range;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, periph_clk_en;
	logic slow_clk_pin, osc_clk_pin, osc_input_pin, pll_clk_pin;
	logic crystal_osc_on, external_clock_passthrough, pll_run, usb_clk, master_clk, master_ready;
	logic [7:0] pll_div_value;
	logic [10:0] pll_ratio_factor;
	logic [2:0] prog_clk, prev_prog;
	logic prev_slow, prev_usb, prev_master;
	logic [7:0] tick;
	logic [2:0] phase;
	int error_cnt, check_count, n_slow, n_usb, n_master, d_master, d_usb;
	int n_prog[3];
	int d_prog[3];

	assign hready = hreadyout;

	clock_control #(.NPCK(3)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .slow_clk_pin(slow_clk_pin), .osc_clk_pin(osc_clk_pin), .osc_input_pin(osc_input_pin),
		.pll_clk_pin(pll_clk_pin), .crystal_osc_on(crystal_osc_on),
		.external_clock_passthrough(external_clock_passthrough), .pll_div_value(pll_div_value),
		.pll_ratio_factor(pll_ratio_factor), .pll_range(pll_range), .pll_run(pll_run), .usb_clk(usb_clk),
		.master_clk(master_clk), .prog_clk(prog_clk), .master_ready(master_ready), .periph_clk_en(periph_clk_en));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// =========================================================
	// source clocks and edge counters
	// slow 16, main 4, external 8, pll 6 bus cycles; phases kept >= 2 cycles for the synchronisers
	always @(posedge hclk) begin
		tick <= tick + 8'h01;
		phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
		slow_clk_pin <= tick[3];
		osc_clk_pin <= tick[1];
		osc_input_pin <= tick[2];
		pll_clk_pin <= (phase < 3'h3);
		prev_slow <= slow_clk_pin;
		prev_usb <= usb_clk;
		prev_master <= master_clk;
		prev_prog <= prog_clk;
		if (slow_clk_pin && !prev_slow) n_slow <= n_slow + 1;
		if (usb_clk && !prev_usb) n_usb <= n_usb + 1;
		if (master_clk && !prev_master) n_master <= n_master + 1;
		for (int i = 0; i < 3; i++) begin
			if (prog_clk[i] && !prev_prog[i]) n_prog[i] <= n_prog[i] + 1;
		end
	end

	// =========================================================
	// helpers
	function automatic logic in_range(input int x, input int lo, input int hi);
		return (x >= lo && x <= hi);
	endfunction

	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task hang(input string m);
		error_cnt++;
		$display("ERROR %0t %s", $time, m);
		print_verdict();
	endtask

	task automatic wait_hready;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (k >= 50) hang("bus stuck");
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		wait_hready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_hready();
		@(negedge hclk);
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		wait_hready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		wait_hready();
		d = hrdata;
		@(negedge hclk);
	endtask

	// reads until one bit reaches a level; reports the slow edges seen meanwhile
	task automatic poll(input logic [7:0] a, input int b, input logic v, output int slow_seen);
		logic [31:0] r;
		int s0, k;
		s0 = n_slow;
		k = 0;
		do begin
			bus_read(a, r);
			k++;
		end while (r[b] !== v && k < 1000);
		if (k >= 1000) hang("poll timeout");
		slow_seen = n_slow - s0;
	endtask

	// ready drops one cycle after the write lands, so look from the next cycle on
	task automatic wait_master(output int k);
		k = 0;
		do begin
			@(negedge hclk);
			k++;
		end while (master_ready !== 1'b1 && k < 3000);
		if (k >= 3000) hang("master ready timeout");
	endtask

	task automatic window(input int n);
		int m0, u0;
		int p0[3];
		m0 = n_master;
		u0 = n_usb;
		p0 = n_prog;
		repeat (n) @(posedge hclk);
		d_master = n_master - m0;
		d_usb = n_usb - u0;
		for (int i = 0; i < 3; i++) d_prog[i] = n_prog[i] - p0[i];
	endtask

	// =========================================================
	// scenarios
	task automatic t_reset;
		logic [31:0] r;
		bus_read(OFF_STATUS, r);
		`CHK(r, 32'h0000_0008, "status after reset")
		bus_read(OFF_PLL_CFG, r);
		`CHK(r, PLL_RESET, "pll after reset")
		bus_read(OFF_PER_STATE, r);
		`CHK(r, 32'h0, "gates after reset")
		bus_read(OFF_MEASURE, r);
		`CHK(r, 32'h0, "measure after reset")
		bus_read(8'hfc, r);
		`CHK(r, 32'h0, "unmapped read")
		`CHK({hreadyout, hresp}, 2'b10, "bus response okay")
		$display("test reset done");
	endtask

	task automatic t_periph;
		logic [31:0] r;
		bus_write(OFF_PER_ENABLE, 32'hffff_ffff);
		bus_read(OFF_PER_STATE, r);
		`CHK(r, PER_MASK, "all gates on")
		bus_write(OFF_PER_DISABLE, 32'h8000_0007);
		bus_read(OFF_PER_STATE, r);
		`CHK(r, 32'h7fff_fff8, "gates 2 and 31 off")
		bus_write(OFF_PER_DISABLE, 32'h0);
		bus_write(OFF_PER_STATE, 32'h0);
		bus_read(OFF_PER_STATE, r);
		`CHK(r, 32'h7fff_fff8, "zero write kept gates")
		bus_read(OFF_PER_DISABLE, r);
		`CHK(r, 32'h0, "write-only reads zero")
		`CHK(periph_clk_en, 32'h7fff_fff8, "gate vector")
		$display("test periph done");
	endtask

	task automatic t_osc;
		logic [31:0] r;
		int n;
		bus_write(OFF_OSC_CTRL, 32'h0000_0201);
		`CHK(crystal_osc_on, 1'b1, "osc on")
		poll(OFF_STATUS, ST_STABLE_BIT, 1'b1, n);
		`CHK(in_range(n, 15, 17), 1'b1, "startup length")
		poll(OFF_MEASURE, MEAS_VALID_BIT, 1'b1, n);
		bus_read(OFF_MEASURE, r);
		`CHK(in_range(int'(r[15:0]), 62, 66), 1'b1, "measured count")
		bus_write(OFF_OSC_CTRL, 32'h0);
		bus_read(OFF_STATUS, r);
		`CHK(r[ST_STABLE_BIT], 1'b0, "stable cleared")
		bus_read(OFF_MEASURE, r);
		`CHK(r[MEAS_VALID_BIT], 1'b0, "valid cleared")
		`CHK(crystal_osc_on, 1'b0, "osc off")
		$display("test osc done");
	endtask

	task automatic t_bypass;
		logic [31:0] r;
		bus_write(OFF_OSC_CTRL, 32'h0000_ff02);
		`CHK(external_clock_passthrough, 1'b1, "bypass on")
		bus_read(OFF_STATUS, r);
		`CHK(r[ST_STABLE_BIT], 1'b1, "stable at once")
		bus_write(OFF_OSC_CTRL, 32'h3);
		`CHK(crystal_osc_on, 1'b0, "bypass wins")
		bus_write(OFF_OSC_CTRL, 32'h0);
		bus_read(OFF_STATUS, r);
		`CHK(r[ST_STABLE_BIT], 1'b0, "stable cleared")
		$display("test bypass done");
	endtask

	task automatic t_pll;
		logic [31:0] r;
		int n;
		bus_write(OFF_PLL_CFG, 32'h0003_0401);
		`CHK({pll_run, pll_div_value, pll_ratio_factor}, {1'b1, 8'h01, 11'h003}, "pll fields")
		bus_read(OFF_STATUS, r);
		`CHK(r[ST_LOCK_BIT], 1'b0, "lock cleared by write")
		poll(OFF_STATUS, ST_LOCK_BIT, 1'b1, n);
		`CHK(in_range(n, 3, 5), 1'b1, "lock wait")
		for (int c = 0; c < 3; c++) begin
			bus_write(OFF_PLL_CFG, 32'h0003_0401 | (c << 28));
			window(480);
			`CHK(in_range(d_usb, (80 >> c) - 1, (80 >> c) + 1), 1'b1, "usb rate")
		end
		bus_write(OFF_PLL_CFG, 32'hffff_ffff);
		bus_read(OFF_PLL_CFG, r);
		`CHK(r, PLL_MASK, "pll field widths")
		`CHK(pll_range, 2'h3, "range field")
		bus_write(OFF_PLL_CFG, 32'h0003_0400);
		`CHK(pll_run, 1'b0, "divider zero stops")
		bus_read(OFF_STATUS, r);
		`CHK(r[ST_LOCK_BIT], 1'b0, "no lock when stopped")
		bus_write(OFF_PLL_CFG, 32'h0000_0401);
		`CHK(pll_run, 1'b0, "ratio zero stops")
		// leave the PLL running for the clock source tests
		bus_write(OFF_PLL_CFG, 32'h0003_0401);
		$display("test pll done");
	endtask

	task automatic t_master;
		logic [31:0] r;
		int k;
		// main clock must run for the main-source cases; bypass kept clear
		bus_write(OFF_OSC_CTRL, 32'h0000_0001);
		for (int s = 0; s < 3; s++) begin
			bus_write(OFF_MCK_SEL, {27'h0, 3'(s), SRC_MAIN});
			wait_master(k);
			window(512);
			`CHK(in_range(d_master, (128 >> s) - 1, (128 >> s) + 1), 1'b1, "main prescale")
		end
		// a prescaled switch costs 64 new-source edges, about 256 bus cycles here
		bus_write(OFF_MCK_SEL, {27'h0, 3'h1, SRC_MAIN});
		@(negedge hclk);
		`CHK(master_ready, 1'b0, "ready drops")
		wait_master(k);
		`CHK(in_range(k, 240, 290), 1'b1, "prescaled switch time")
		bus_write(OFF_MCK_SEL, {27'h0, SCALE_NONE, SRC_SLOW});
		wait_master(k);
		window(512);
		`CHK(in_range(d_master, 31, 33), 1'b1, "slow source")
		bus_write(OFF_MCK_SEL, 32'h2);
		wait_master(k);
		window(512);
		`CHK(d_master, 0, "reserved source idle")
		bus_read(OFF_MCK_SEL, r);
		`CHK(r, 32'h2, "master readback")
		bus_write(OFF_MCK_SEL, {27'h0, SCALE_NONE, SRC_PLL});
		wait_master(k);
		window(512);
		`CHK(in_range(d_master, 84, 86), 1'b1, "pll source")
		$display("test master done");
	endtask

	task automatic t_prog;
		logic [31:0] r;
		int n;
		bus_write(OFF_PCK_BASE, {27'h0, 3'h1, SRC_SLOW});
		bus_write(OFF_PCK_BASE + 8'h04, {27'h0, SCALE_NONE, SRC_PLL});
		bus_write(OFF_PCK_BASE + 8'h08, {27'h0, 3'h2, SRC_MAIN});
		for (int i = 0; i < 3; i++) poll(OFF_STATUS, ST_PCK_READY_LSB + i, 1'b1, n);
		window(960);
		`CHK(in_range(d_prog[0], 29, 31), 1'b1, "output 0 rate")
		`CHK(in_range(d_prog[1], 159, 161), 1'b1, "output 1 rate")
		`CHK(in_range(d_prog[2], 59, 61), 1'b1, "output 2 rate")
		bus_read(OFF_PCK_BASE + 8'h08, r);
		`CHK(r, 32'h9, "output 2 readback")
		$display("test prog done");
	endtask

	// =========================================================
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{tick, phase, slow_clk_pin, osc_clk_pin, osc_input_pin, pll_clk_pin} = '0;
		{prev_slow, prev_usb, prev_master, prev_prog} = '0;
		{error_cnt, check_count, n_slow, n_usb, n_master} = '0;
		n_prog = '{0, 0, 0};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_periph();
		t_osc();
		t_bypass();
		t_pll();
		t_master();
		t_prog();
		print_verdict();
	end
endmodule

`default_nettype wire
